// file: psh_ping_sync.sv
/*
 * ping synchronisation handshake: ready line, ping command input, active-low
 * transmit trigger, and a seconds counter aligned by the pulse-per-second input.
 * assumes the ping engine reports the end of the receive period with rx_done
 * (one mclk pulse, same clock domain); ping_cmd and pps_n are asynchronous pins.
 */
`include "psh_regs.svh"
`default_nettype none
module psh_ping_sync #(
    parameter int TRIG_CYC = `PSH_TRIG_CYC,
    parameter int TICK_PER_SEC = `PSH_TICK_PER_SEC
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ping_cmd,
    input wire logic pps_n,
    input wire logic sync_enable,
    input wire logic rx_done,
    output logic ready,
    output logic trig_n,
    output logic ping_start,
    output logic [31:0] seconds,
    output logic pps_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] cmd_sync;
    logic [1:0] pps_sync;
    logic pps_prev;
    // two flops per pin; only the second stage feeds logic
    // each chain resets to its pin's idle level, or a phantom ping follows reset
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cmd_sync <= `PSH_CMD_SYNC_RST;
            pps_sync <= `PSH_SYNC_RST;
            pps_prev <= 1'b1;
        end else begin
            cmd_sync <= {cmd_sync[0], ping_cmd};
            pps_sync <= {pps_sync[0], pps_n};
            pps_prev <= pps_sync[1];
        end
    end
    logic cmd_s;
    logic pps_fall;
    assign cmd_s = cmd_sync[1];
    assign pps_fall = pps_prev & ~pps_sync[1];

    // shared 32-bit increment for the counters below
    function automatic logic [31:0] inc32(input logic [31:0] v);
        return v + `PSH_ONE;
    endfunction : inc32

    // ----------------------------------------------------------------
    // ping handshake state machine
    // ----------------------------------------------------------------
    psh_pkg::psh_state_e state, next_state;
    logic [31:0] tcnt, next_tcnt;
    logic next_ready, next_trig_n, next_ping_start;
    // a ping command is honoured only from the ready state, so a long high
    // command simply chains pings back to back at the engine's own rate
    always_comb begin
        next_state = state;
        next_tcnt = tcnt;
        next_ready = ready;
        next_trig_n = 1'b1;
        next_ping_start = 1'b0;
        unique case (state)
            psh_pkg::PSH_READY: begin
                next_ready = 1'b1;
                if (cmd_s || !sync_enable) begin
                    next_state = psh_pkg::PSH_TRIG;
                    next_ready = 1'b0;
                    next_trig_n = 1'b0;
                    next_ping_start = 1'b1;
                    next_tcnt = `PSH_ONE;
                end
            end
            psh_pkg::PSH_TRIG: begin
                next_ready = 1'b0;
                if (tcnt >= 32'(TRIG_CYC)) begin
                    next_state = psh_pkg::PSH_BUSY;
                    next_tcnt = `PSH_CNT_ZERO;
                end else begin
                    next_trig_n = 1'b0;
                    next_tcnt = inc32(tcnt);
                end
            end
            psh_pkg::PSH_BUSY: begin
                next_ready = 1'b0;
                if (rx_done) begin
                    next_state = psh_pkg::PSH_READY;
                    next_ready = 1'b1;
                end
            end
            default: begin
                next_state = psh_pkg::PSH_READY;
                next_ready = 1'b0;
            end
        endcase
    end
    // handshake registers; outputs come straight from these flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state <= psh_pkg::PSH_READY;
            tcnt <= `PSH_CNT_ZERO;
            ready <= 1'b0;
            trig_n <= 1'b1;
            ping_start <= 1'b0;
        end else begin
            state <= next_state;
            tcnt <= next_tcnt;
            ready <= next_ready;
            trig_n <= next_trig_n;
            ping_start <= next_ping_start;
        end
    end

    // ----------------------------------------------------------------
    // seconds counter
    // ----------------------------------------------------------------
    logic [31:0] subsec, next_subsec;
    logic [31:0] next_seconds;
    logic next_pps_seen;
    // the pps edge snaps the fraction to zero and rounds the second:
    // a late edge (fraction below half) means the free count already rolled
    always_comb begin
        next_subsec = inc32(subsec);
        next_seconds = seconds;
        next_pps_seen = 1'b0;
        if (pps_fall) begin
            next_subsec = `PSH_CNT_ZERO;
            next_pps_seen = 1'b1;
            if (subsec < 32'(TICK_PER_SEC / 2)) begin
                next_seconds = seconds;
            end else begin
                next_seconds = inc32(seconds);
            end
        end else if (subsec >= 32'(TICK_PER_SEC - 1)) begin
            next_subsec = `PSH_CNT_ZERO;
            next_seconds = inc32(seconds);
        end
    end
    // seconds registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            subsec <= `PSH_CNT_ZERO;
            seconds <= `PSH_CNT_ZERO;
            pps_seen <= 1'b0;
        end else begin
            subsec <= next_subsec;
            seconds <= next_seconds;
            pps_seen <= next_pps_seen;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    logic [31:0] low_cnt, next_low_cnt;
    // checker helper: length of the current trigger low phase; a counter
    // keeps the width check cheap where a long repetition would not
    always_comb begin
        next_low_cnt = trig_n ? `PSH_CNT_ZERO : inc32(low_cnt);
    end
    // checker helper register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            low_cnt <= `PSH_CNT_ZERO;
        end else begin
            low_cnt <= next_low_cnt;
        end
    end
    AST_TRIG_WIDTH: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(trig_n) |-> low_cnt == 32'(TRIG_CYC))
        else $error("trigger low width wrong");
    AST_TRIG_MAX: assert property (@(posedge mclk) disable iff (!rstn)
        !trig_n |-> low_cnt < 32'(TRIG_CYC))
        else $error("trigger low too long");
    AST_READY_DROP: assert property (@(posedge mclk) disable iff (!rstn)
        (state == psh_pkg::PSH_READY && (cmd_s || !sync_enable)) |=> (!ready && !trig_n))
        else $error("ping not started on command");
    AST_BUSY_NOT_READY: assert property (@(posedge mclk) disable iff (!rstn)
        !trig_n |-> !ready)
        else $error("ready high during transmit");
    AST_RX_DONE: assert property (@(posedge mclk) disable iff (!rstn)
        (state == psh_pkg::PSH_BUSY && rx_done) |=> ready)
        else $error("ready not raised after receive");
    AST_WAIT: assert property (@(posedge mclk) disable iff (!rstn)
        (state == psh_pkg::PSH_READY && !cmd_s && sync_enable) |=> trig_n)
        else $error("ping without command");
    AST_FREE_RUN: assert property (@(posedge mclk) disable iff (!rstn)
        (state == psh_pkg::PSH_READY && !sync_enable) |=> $fell(trig_n))
        else $error("no free-running ping");
    AST_PPS_ALIGN: assert property (@(posedge mclk) disable iff (!rstn)
        pps_fall |=> (subsec == `PSH_CNT_ZERO && pps_seen))
        else $error("pps did not align counter");
    AST_PPS_SYNC: assert property (@(posedge mclk) disable iff (!rstn)
        $fell(pps_n) ##1 !pps_n ##1 !pps_n |=> pps_fall || $past(pps_fall))
        else $error("pps edge not seen");
    AST_TRIG_ONE_START: assert property (@(posedge mclk) disable iff (!rstn)
        ping_start |-> !trig_n)
        else $error("start without trigger");
    AST_START_PULSE: assert property (@(posedge mclk) disable iff (!rstn)
        ping_start |=> !ping_start)
        else $error("start pulse longer than one cycle");
    AST_PPS_PULSE: assert property (@(posedge mclk) disable iff (!rstn)
        pps_seen |=> !pps_seen)
        else $error("pps flag longer than one cycle");
    AST_SECONDS_STEP: assert property (@(posedge mclk) disable iff (!rstn)
        $changed(seconds) |-> seconds == inc32($past(seconds)))
        else $error("seconds jumped by more than one");
endmodule : psh_ping_sync
`default_nettype wire

// file: psh_regs.svh
/*
 * timing constants of the ping synchronisation handshake.
 * assumes a 50 MHz system clock; counts derive from times and the rate.
 */
`ifndef PSH_REGS_SVH
`define PSH_REGS_SVH

`define PSH_CLK_HZ 50000000
`define PSH_TRIG_TIME_NS 20000
`define PSH_TRIG_CYC ((`PSH_TRIG_TIME_NS * (`PSH_CLK_HZ / 1000000) + 999) / 1000)
`define PSH_TICK_PER_SEC `PSH_CLK_HZ
`define PSH_SYNC_RST 2'h3
// the ping command rests low, so its synchroniser must rest low as well
`define PSH_CMD_SYNC_RST 2'h0
`define PSH_CNT_ZERO 32'h0
`define PSH_ONE 32'h1

`endif

// file: psh_pkg.sv
/*
 * types shared by the ping synchronisation handshake.
 * assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package psh_pkg;
    timeunit 1ns;
    timeprecision 1ps;
    typedef enum logic [1:0] {
        PSH_READY = 2'b00,
        PSH_TRIG  = 2'b01,
        PSH_BUSY  = 2'b10
    } psh_state_e;
endpackage : psh_pkg
`default_nettype wire

// file: psh_sync_partner.sv
/*
 * model of the external sync controller: drives the ping command and the
 * pulse-per-second line. assumes the device's mclk and ready.
 */
`default_nettype none
module psh_sync_partner #(
    parameter int HOLD_CYC = 8,
    parameter int PPS_LOW = 6
) (
    input wire logic mclk,
    input wire logic want,
    input wire logic pps_go,
    input wire logic ready,
    output logic ping_cmd = 1'b0,
    output logic pps_n = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    int hold = 0;
    int low = 0;
    // command raised only while the bench wants a ping and ready is high; never shorter than HOLD_CYC
    always @(posedge mclk) begin
        hold <= ping_cmd ? hold + 1 : 0;
        if (!ping_cmd && want && ready)
            ping_cmd <= 1'b1;
        else if (ping_cmd && !want && hold >= HOLD_CYC)
            ping_cmd <= 1'b0;
        low <= pps_go ? PPS_LOW : (low > 0 ? low - 1 : 0);
        pps_n <= !(pps_go || low > 1);
    end
endmodule : psh_sync_partner
`default_nettype wire

// file: psh_tb.sv
/*
 * self-checking bench of the ping handshake with shortened counts.
 * assumes the partner model drives ping_cmd and pps_n.
 */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TRIG = 20;
    localparam int TICK = 100;
    logic mclk = 0, rstn = 0, sync_enable = 1, rx_done = 0, want = 0, pps_go = 0;
    logic ping_cmd, pps_n, ready, trig_n, ping_start, pps_seen;
    logic [31:0] seconds;
    int miscompares = 0, cmp_count = 0, cycles = 0;
    psh_ping_sync #(.TRIG_CYC(TRIG), .TICK_PER_SEC(TICK)) dut_u (.mclk(mclk), .rstn(rstn),
        .ping_cmd(ping_cmd), .pps_n(pps_n), .sync_enable(sync_enable), .rx_done(rx_done),
        .ready(ready), .trig_n(trig_n), .ping_start(ping_start), .seconds(seconds),
        .pps_seen(pps_seen));
    psh_sync_partner far_u (.mclk(mclk), .want(want), .pps_go(pps_go), .ready(ready),
        .ping_cmd(ping_cmd), .pps_n(pps_n));
    initial forever #10 mclk = ~mclk;
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // a hang counts as a mismatch
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    // inputs always change 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic pulse_rx;
        rx_done = 1;
        tick(1);
        rx_done = 0;
    endtask : pulse_rx
    task automatic t_pps(input logic [31:0] exp);
        int i;
        pps_go = 1;
        tick(1);
        pps_go = 0;
        for (i = 0; i < 8 && pps_seen !== 1'b1; i++) tick(1);
        check("pps_seen", pps_seen, 1'b1);
        check("seconds at pps", seconds, exp);
    endtask : t_pps
    task automatic t_ping;
        int i;
        int n;
        want = 1;
        for (i = 0; i < 8 && trig_n !== 1'b0; i++) tick(1);
        check("ready at trigger", ready, 1'b0);
        check("ping_start", ping_start, 1'b1);
        want = 0;
        for (n = 0; n < 100 && trig_n === 1'b0; n++) tick(1);
        check("trigger width", n, TRIG);
        tick(5);
        check("ready while busy", ready, 1'b0);
        pulse_rx();
        check("ready after rx", ready, 1'b1);
        tick(5);
        check("wait while cmd low", trig_n, 1'b1);
        $display("test ping done");
    endtask : t_ping
    task automatic t_freerun;
        sync_enable = 0;
        tick(2);
        check("free run trigger", trig_n, 1'b0);
        tick(TRIG + 2);
        pulse_rx();
        check("ready one cycle", ready, 1'b1);
        tick(1);
        check("next ping at once", trig_n, 1'b0);
        sync_enable = 1;
        tick(TRIG + 2);
        pulse_rx();
        $display("test free run done");
    endtask : t_freerun
    // command held high chains pings; releasing it stops the chain
    task automatic t_chain;
        int i;
        want = 1;
        for (i = 0; i < 8 && trig_n !== 1'b0; i++) tick(1);
        check("chain first trigger", trig_n, 1'b0);
        tick(TRIG + 2);
        pulse_rx();
        check("chain ready", ready, 1'b1);
        tick(1);
        check("chain next ping", trig_n, 1'b0);
        check("chain start pulse", ping_start, 1'b1);
        want = 0;
        tick(TRIG + 2);
        pulse_rx();
        tick(5);
        check("chain stops", trig_n, 1'b1);
        $display("test chain done");
    endtask : t_chain
    initial begin
        tick(1);
        check("ready in reset", ready, 1'b0);
        check("trig_n in reset", trig_n, 1'b1);
        tick(7);
        rstn = 1;
        tick(3);
        check("ready after reset", ready, 1'b1);
        $display("test reset done");
        t_pps(32'h0);
        tick(60);
        check("seconds restarted", seconds, 32'h0);
        tick(45);
        check("seconds free run", seconds, 32'h1);
        tick(60);
        t_pps(32'h2);
        $display("test pps done");
        t_ping();
        t_freerun();
        t_chain();
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
